// ==== core/lbepc_ctrl.sv ====
`timescale 1ns/1ps
module lbepc_ctrl #(
    parameter int unsigned EN_OFF_CYC = lbepc_pkg::EN_OFF_CYC,
    parameter int unsigned PWM_OFF_CYC = lbepc_pkg::PWM_OFF_CYC,
    parameter int unsigned SEL_CYC = lbepc_pkg::SEL_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic enable_line_signal_i,
    input wire logic pwm_i,
    input wire logic sw_ovp_i,
    input wire logic led_one_ovp_i,
    input wire logic led_two_ovp_i,
    input wire logic ocp_i,
    input wire logic supply_undervoltage_lockout_i,
    input wire logic otp_i,
    input wire logic led_one_gnd_i,
    input wire logic led_two_gnd_i,
    input wire logic cycle_start_i,
    output logic enabled_o,
    output logic digital_mode_o,
    output logic boost_run_o,
    output logic gate_on_o,
    output logic sink_one_en_o,
    output logic sink_two_en_o,
    output logic ovp_latched_o
);
    import lbepc_pkg::*;

    logic [IN_W-1:0] in_raw; // raw asynchronous inputs
    logic [IN_W-1:0] sync1_reg; // first stage, read only by second
    logic [IN_W-1:0] sync2_reg; // synchronised inputs
    logic en_s, pwm_s, sw_ovp_s, led_ovp_s, ocp_s, supply_undervoltage_lockout_s, otp_s, g1_s, g2_s;
    logic en_prev_reg; // enable one cycle back, for edge detect
    logic en_rise; // enable rising edge
    lbepc_state_t state_reg; // operating state
    logic digital_reg; // selected dimming mode, 1 = digital
    logic parked_reg; // off after pwm timeout, pwm may re-enable
    logic [ENT_W-1:0] hi_cnt_reg; // entry high time
    logic [ENT_W-1:0] lo_cnt_reg; // entry low time
    logic ent_fail_reg; // entry pattern broken
    logic ent_hit_reg; // entry pattern recognised
    logic [3:0] ovp_cnt_reg; // consecutive overvoltage cycles
    logic ovp_latch_reg; // overvoltage latch-off
    logic gate_reg; // power switch on
    logic dim_gate; // dimming allows switching
    logic both_gnd; // both channels grounded

    lbepc_tmr_if en_t (); // enable low timer
    lbepc_tmr_if pwm_t (); // pwm low timer
    lbepc_tmr_if sel_t (); // mode select window

    assign in_raw = {led_two_gnd_i, led_one_gnd_i, otp_i, supply_undervoltage_lockout_i, ocp_i,
        led_two_ovp_i, led_one_ovp_i, sw_ovp_i, pwm_i, enable_line_signal_i};

    // two-flop synchroniser on every input except cycle_start_i and srst_i
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            en_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= in_raw;
            sync2_reg <= sync1_reg;
            en_prev_reg <= sync2_reg[IX_EN];
        end
    end

    assign en_s = sync2_reg[IX_EN];
    assign pwm_s = sync2_reg[IX_PWM];
    assign sw_ovp_s = sync2_reg[IX_SWOVP];
    assign led_ovp_s = sync2_reg[IX_L1OVP] | sync2_reg[IX_L2OVP];
    assign ocp_s = sync2_reg[IX_OCP];
    assign supply_undervoltage_lockout_s = sync2_reg[IX_SUPPLY_UNDERVOLTAGE_LOCKOUT];
    assign otp_s = sync2_reg[IX_OTP];
    assign g1_s = sync2_reg[IX_L1GND];
    assign g2_s = sync2_reg[IX_L2GND];
    assign en_rise = en_s & ~en_prev_reg;

    // timers: enable low, pwm low in pwm mode, select window
    // also runs while parked, so a long enable low there is a full shutdown
    assign en_t.run = ~en_s & ((state_reg != LBEPC_OFF) | parked_reg);
    assign pwm_t.run = ~pwm_s & ~digital_reg & (state_reg == LBEPC_ACTIVE);
    assign sel_t.run = (state_reg == LBEPC_SELECT);

    lbepc_tmr #(.LIMIT(EN_OFF_CYC)) u_en_tmr (.clk_i(clk_i), .srst_i(srst_i), .t(en_t));
    lbepc_tmr #(.LIMIT(PWM_OFF_CYC)) u_pwm_tmr (.clk_i(clk_i), .srst_i(srst_i), .t(pwm_t));
    lbepc_tmr #(.LIMIT(SEL_CYC - 1)) u_sel_tmr (.clk_i(clk_i), .srst_i(srst_i), .t(sel_t));

    // operating state and dimming mode
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= LBEPC_OFF;
            digital_reg <= 1'b0;
            parked_reg <= 1'b0;
        end
        else if (en_t.expired)
        begin
            // full disable: next enable edge is a fresh startup
            state_reg <= LBEPC_OFF;
            parked_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                LBEPC_OFF:
                begin
                    if (parked_reg && en_s && pwm_s)
                    begin
                        state_reg <= LBEPC_ACTIVE;
                        parked_reg <= 1'b0;
                    end
                    else if (en_rise && !parked_reg)
                    begin
                        state_reg <= LBEPC_SELECT; // startup
                        digital_reg <= 1'b0;
                    end
                end
                LBEPC_SELECT:
                begin
                    if (sel_t.expired)
                    begin
                        // pwm unless the entry pattern was seen
                        digital_reg <= ent_hit_reg;
                        state_reg <= LBEPC_ACTIVE;
                    end
                end
                LBEPC_ACTIVE:
                begin
                    if (pwm_t.expired)
                    begin
                        state_reg <= LBEPC_OFF;
                        parked_reg <= 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= LBEPC_OFF;
                end
            endcase
        end
    end

    // digital entry pattern detector inside the select window
    always_ff @(posedge clk_i)
    begin
        if (srst_i || state_reg != LBEPC_SELECT)
        begin
            hi_cnt_reg <= '0;
            lo_cnt_reg <= '0;
            ent_fail_reg <= 1'b0;
            ent_hit_reg <= 1'b0;
        end
        else if (!ent_hit_reg && !ent_fail_reg)
        begin
            if (en_s)
            begin
                // high again before the low time ends breaks the pattern
                if (lo_cnt_reg != '0)
                begin
                    ent_fail_reg <= 1'b1;
                end
                else if (hi_cnt_reg != ENT_W'(ENTRY_HI_CYC + 1))
                begin
                    hi_cnt_reg <= hi_cnt_reg + ENT_W'(1);
                end
            end
            else if (hi_cnt_reg <= ENT_W'(ENTRY_HI_CYC))
            begin
                ent_fail_reg <= 1'b1;
            end
            else if (lo_cnt_reg == ENT_W'(ENTRY_LO_CYC - 1))
            begin
                ent_hit_reg <= 1'b1;
            end
            else
            begin
                lo_cnt_reg <= lo_cnt_reg + ENT_W'(1);
            end
        end
    end

    // overvoltage cycle counter and latch-off
    always_ff @(posedge clk_i)
    begin
        if (srst_i || en_t.expired)
        begin
            ovp_cnt_reg <= '0;
            ovp_latch_reg <= 1'b0;
        end
        else if (cycle_start_i)
        begin
            if (!sw_ovp_s)
            begin
                ovp_cnt_reg <= '0;
            end
            else if (ovp_cnt_reg == OVP_LATCH_CYC - 4'h1)
            begin
                ovp_latch_reg <= 1'b1;
            end
            else
            begin
                ovp_cnt_reg <= ovp_cnt_reg + 4'h1;
            end
        end
    end

    // dimming gate and converter run condition
    assign dim_gate = digital_reg ? en_s : pwm_s;
    assign both_gnd = g1_s & g2_s;
    assign boost_run_o = (state_reg == LBEPC_ACTIVE) & dim_gate & ~both_gnd
        & ~sw_ovp_s & ~led_ovp_s
        & ~supply_undervoltage_lockout_s & ~otp_s & ~ovp_latch_reg;

    // power switch: on at cycle start, off on overcurrent
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !boost_run_o || ocp_s)
        begin
            gate_reg <= 1'b0;
        end
        else if (cycle_start_i)
        begin
            gate_reg <= 1'b1;
        end
    end

    assign gate_on_o = gate_reg;
    assign enabled_o = (state_reg == LBEPC_ACTIVE);
    assign digital_mode_o = digital_reg;
    // sinks keep running through led overvoltage
    assign sink_one_en_o = enabled_o & ~g1_s;
    assign sink_two_en_o = enabled_o & ~g2_s;
    assign ovp_latched_o = ovp_latch_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    pwm_fallback_a: assert property ((state_reg == LBEPC_SELECT) && sel_t.expired
        && !ent_hit_reg && !en_t.expired |=> !digital_reg && enabled_o)
        else $error("no pwm fallback");
    pwm_enable_a: assert property ((state_reg == LBEPC_OFF) && parked_reg && en_s && pwm_s
        && !en_t.expired |=> enabled_o)
        else $error("pwm did not re-enable");
    en_timeout_a: assert property (en_t.expired |=> state_reg == LBEPC_OFF)
        else $error("enable timeout ignored");
    pwm_timeout_a: assert property (pwm_t.expired && enabled_o |=> !enabled_o)
        else $error("pwm timeout ignored");
    sw_ovp_a: assert property (sw_ovp_s |-> !boost_run_o ##1 !gate_on_o)
        else $error("switching during overvoltage");
    ovp_latch_a: assert property (cycle_start_i && sw_ovp_s
        && ovp_cnt_reg == OVP_LATCH_CYC - 4'h1
        && !en_t.expired |=> ovp_latched_o)
        else $error("overvoltage latch missed");
    latch_hold_a: assert property (ovp_latched_o && !en_t.expired |=> ovp_latched_o)
        else $error("latch released early");
    led_ovp_a: assert property (led_ovp_s && enabled_o && !g1_s |-> !boost_run_o
        && sink_one_en_o)
        else $error("led overvoltage handling");
    gnd_sink_a: assert property (g1_s |-> !sink_one_en_o)
        else $error("grounded channel sink on");
    ocp_off_a: assert property (ocp_s |=> !gate_on_o)
        else $error("switch on through overcurrent");
    lockout_a: assert property (supply_undervoltage_lockout_s || otp_s || both_gnd |-> !boost_run_o)
        else $error("converter runs in lockout");
    ovp_count_a: assert property (cycle_start_i && !sw_ovp_s && !en_t.expired
        |=> ovp_cnt_reg == 4'h0)
        else $error("overvoltage count not cleared");

    digital_cv: cover property ((state_reg == LBEPC_SELECT) ##1 digital_reg && enabled_o);
    pwm_park_cv: cover property (pwm_t.expired ##[1:300] enabled_o);
    ovp_latch_cv: cover property ($rose(ovp_latched_o));
    ocp_cv: cover property (gate_on_o ##1 ocp_s ##1 !gate_on_o);
endmodule

// ==== core/lbepc_pkg.sv ====
package lbepc_pkg;
    // clock period of the control clock
    localparam int unsigned CLK_NS = 100;
    // enable low time that ends operation, in microseconds
    localparam int unsigned T_EN_OFF_US = 2500;
    // pwm low time that ends operation, in microseconds
    localparam int unsigned T_PWM_OFF_US = 20000;
    // mode select window after startup, in microseconds
    localparam int unsigned T_SEL_US = 1000;
    // digital entry high and low times, in microseconds
    localparam int unsigned T_ENTRY_HI_US = 100;
    localparam int unsigned T_ENTRY_LO_US = 260;
    // least times round up
    localparam int unsigned EN_OFF_CYC = (T_EN_OFF_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PWM_OFF_CYC = (T_PWM_OFF_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ENTRY_HI_CYC = (T_ENTRY_HI_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ENTRY_LO_CYC = (T_ENTRY_LO_US * 1000 + CLK_NS - 1) / CLK_NS;
    // longest time rounds down
    localparam int unsigned SEL_CYC = (T_SEL_US * 1000) / CLK_NS;
    // timer counter width, covers the longest timeout
    localparam int unsigned TMR_W = 18;
    // entry pattern counter width
    localparam int unsigned ENT_W = 12;
    // switching cycles of overvoltage before latch-off
    localparam logic [3:0] OVP_LATCH_CYC = 4'h8;
    // synchronised input vector layout
    localparam int unsigned IN_W = 10;
    localparam int unsigned IX_EN = 0;
    localparam int unsigned IX_PWM = 1;
    localparam int unsigned IX_SWOVP = 2;
    localparam int unsigned IX_L1OVP = 3;
    localparam int unsigned IX_L2OVP = 4;
    localparam int unsigned IX_OCP = 5;
    localparam int unsigned IX_SUPPLY_UNDERVOLTAGE_LOCKOUT = 6;
    localparam int unsigned IX_OTP = 7;
    localparam int unsigned IX_L1GND = 8;
    localparam int unsigned IX_L2GND = 9;
    // operating states, gray along off -> select -> active
    typedef enum logic [1:0]
    {
        LBEPC_OFF = 2'h0,
        LBEPC_SELECT = 2'h1,
        LBEPC_ACTIVE = 2'h3
    } lbepc_state_t;
endpackage

// ==== core/lbepc_tmr_if.sv ====
`timescale 1ns/1ps
// carries the run level to a timer and its expiry back
interface lbepc_tmr_if;
    logic run; // timer counts while high, clears while low
    logic expired; // high once run has stayed high longer than the limit
    modport ctrl (output run, input expired);
    modport tmr (input run, output expired);
endinterface

// ==== core/lbepc_tmr.sv ====
`timescale 1ns/1ps
// saturating run-length timer
module lbepc_tmr #(
    parameter int unsigned LIMIT = 1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    lbepc_tmr_if.tmr t
);
    import lbepc_pkg::*;

    logic [TMR_W-1:0] cnt_reg; // cycles of run so far, saturates at limit
    logic exp_reg; // expiry flag

    // count while run is high, clear the moment it drops
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !t.run)
        begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end
        else
        begin
            if (cnt_reg != TMR_W'(LIMIT))
            begin
                cnt_reg <= cnt_reg + TMR_W'(1);
            end
            // expiry after more than limit cycles of run
            exp_reg <= (cnt_reg == TMR_W'(LIMIT));
        end
    end

    assign t.expired = exp_reg;

    // expiry only follows an unbroken run
    tmr_exp_a: assert property (@(posedge clk_i) disable iff (srst_i)
        t.expired |-> $past(t.run))
        else $error("timer expired without run");
endmodule

// ==== verification/lbepc_host_model.sv ====
`timescale 1ns/1ps
// host controller model that drives the enable and pwm pins
module lbepc_host_model (
    input wire logic clk_i,
    output logic en_o,
    output logic pwm_o
);
    import lbepc_pkg::*;
    // both pins start low, so the device sits in off
    initial
    begin
        en_o = 1'b0;
        pwm_o = 1'b0;
    end
    // changes both pins after a falling edge, then keeps them for n cycles
    task automatic hold(input logic en, input logic pwm, input int n);
        @(negedge clk_i);
        en_o = en;
        pwm_o = pwm;
        repeat (n - 1) @(negedge clk_i);
    endtask
    // entry pattern: a long high with pwm high, then a long low, then back high
    task automatic digital_entry();
        hold(1'b1, 1'b1, ENTRY_HI_CYC + 10);
        hold(1'b0, 1'b1, ENTRY_LO_CYC + 10);
        hold(1'b1, 1'b1, 1);
    endtask
    // pwm dimming: enable stays high while pwm alone is changed
    task automatic pwm_level(input logic pwm, input int n);
        hold(1'b1, pwm, n);
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// compares a value with its expectation and counts both outcomes
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %b got %b", nm, (e), (g)); end end
module tb;
    import lbepc_pkg::*;
    // shortened enable timeout, still above the entry low time so that the
    // low phase of the digital entry pattern does not end the startup
    localparam int unsigned EN_OFF = ENTRY_LO_CYC + 400;
    localparam int unsigned PWM_OFF = 200; // shortened pwm timeout
    logic clk = 1'b0; // control clock
    logic srst = 1'b1; // synchronous reset
    logic cs = 1'b0; // switching cycle start pulse
    logic ocp = 1'b0; // overcurrent comparator
    logic g1 = 1'b0; // channel one grounded
    logic g2 = 1'b0; // channel two grounded
    logic [4:0] flt = 5'h00; // supply_undervoltage_lockout, otp, led one ovp, led two ovp, sw ovp
    wire logic en, pwm;
    wire logic enabled, dmode, brun, gate, s1, s2, latched;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    // the host drives the two pins
    lbepc_host_model host (.clk_i(clk), .en_o(en), .pwm_o(pwm));
    lbepc_ctrl #(.EN_OFF_CYC(EN_OFF), .PWM_OFF_CYC(PWM_OFF), .SEL_CYC(SEL_CYC)) dut (
        .clk_i(clk), .srst_i(srst), .enable_line_signal_i(en), .pwm_i(pwm),
        .sw_ovp_i(flt[4]), .led_one_ovp_i(flt[2]), .led_two_ovp_i(flt[3]), .ocp_i(ocp),
        .supply_undervoltage_lockout_i(flt[0]), .otp_i(flt[1]), .led_one_gnd_i(g1), .led_two_gnd_i(g2),
        .cycle_start_i(cs), .enabled_o(enabled), .digital_mode_o(dmode), .boost_run_o(brun),
        .gate_on_o(gate), .sink_one_en_o(s1), .sink_two_en_o(s2), .ovp_latched_o(latched));
    // free running clock
    initial
    begin
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            final_report();
        end
    end
    // waits n falling edges
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one switching cycle start pulse
    task automatic pulse();
        @(negedge clk);
        cs = 1'b1;
        step(1);
        cs = 1'b0;
        step(2);
    endtask
    // prints counts and verdict, then stops
    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // startup without entry pattern, then pwm and enable low times
    task automatic t_pwm();
        host.pwm_level(1'b1, SEL_CYC - 20);
        `CHK("enabled in window", 1'b0, enabled)
        step(40);
        `CHK("enabled", 1'b1, enabled)
        `CHK("digital mode", 1'b0, dmode)
        host.pwm_level(1'b0, PWM_OFF - 10);
        `CHK("enabled short pwm low", 1'b1, enabled)
        host.pwm_level(1'b0, PWM_OFF + 15);
        `CHK("enabled long pwm low", 1'b0, enabled)
        host.pwm_level(1'b1, 5);
        `CHK("enabled pwm high", 1'b1, enabled)
        host.hold(1'b0, 1'b1, EN_OFF - 5);
        host.pwm_level(1'b1, 5);
        `CHK("enabled short en low", 1'b1, enabled)
    endtask
    // each fault stops the converter, grounded channels and overcurrent
    task automatic t_faults();
        for (int i = 0; i < 5; i++)
        begin
            flt = 5'h01 << i;
            step(4);
            `CHK("run in fault", 1'b0, brun)
            if (i == 2 || i == 3)
                `CHK("sinks in led ovp", 1'b1, s1 & s2)
            flt = 5'h00;
            step(4);
            `CHK("run after fault", 1'b1, brun)
        end
        g1 = 1'b1;
        step(4);
        `CHK("sink one grounded", 1'b0, s1)
        `CHK("sink two", 1'b1, s2)
        `CHK("run one grounded", 1'b1, brun)
        g2 = 1'b1;
        step(4);
        `CHK("run both grounded", 1'b0, brun)
        g1 = 1'b0;
        g2 = 1'b0;
        step(4);
        pulse();
        `CHK("gate on", 1'b1, gate)
        ocp = 1'b1;
        step(4);
        `CHK("gate after ocp", 1'b0, gate)
        ocp = 1'b0;
    endtask
    // overvoltage count, its reset, latch-off and clearing by enable low
    task automatic t_ovp();
        flt[4] = 1'b1;
        step(4);
        repeat (7) pulse();
        flt[4] = 1'b0;
        step(4);
        pulse();
        flt[4] = 1'b1;
        step(4);
        repeat (7) pulse();
        `CHK("latched after clear", 1'b0, latched)
        pulse();
        `CHK("latched", 1'b1, latched)
        flt[4] = 1'b0;
        step(4);
        `CHK("run while latched", 1'b0, brun)
        host.hold(1'b0, 1'b1, EN_OFF + 10);
        `CHK("enabled after en low", 1'b0, enabled)
        `CHK("latch cleared", 1'b0, latched)
    endtask
    // restart with the entry pattern selects digital dimming
    task automatic t_digital();
        host.digital_entry();
        step(SEL_CYC - ENTRY_HI_CYC - ENTRY_LO_CYC);
        `CHK("digital mode", 1'b1, dmode)
        `CHK("enabled restart", 1'b1, enabled)
        host.hold(1'b1, 1'b0, PWM_OFF + 15);
        `CHK("pwm low in digital", 1'b1, enabled)
    endtask
    // main sequence
    initial
    begin
        step(2);
        srst = 1'b0;
        step(1);
        `CHK("enabled reset", 1'b0, enabled)
        `CHK("latched reset", 1'b0, latched)
        t_pwm();
        t_faults();
        t_ovp();
        t_digital();
        final_report();
    end
endmodule
